// file: hw/eebac_pkg.sv
// Purpose: constants for the byte eeprom access controller
// Assumes: axi4-lite register bus, 32-bit data, one word per register
// Notes:   program timing counts in cycles of the calibrated oscillator, stall and arm window counts in clk cycles
package eebac_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] ADDR_LOW_OFS  = 4'h0;
  localparam logic [3:0] ADDR_HIGH_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS      = 4'h8;
  localparam logic [3:0] CTRL_OFS      = 4'hC;
  // ==========================================================
  // control register fields
  localparam int RD_STROBE_BIT = 0;
  localparam int PROG_BIT      = 1;
  localparam int ARM_BIT       = 2;
  localparam int MODE_LSB      = 4;
  localparam int MODE_W        = 2;
  // ==========================================================
  // sizes and counts
  localparam int ADDR_W        = 9;
  localparam int DEPTH         = 512;
  localparam int ARM_WINDOW    = 4;
  localparam int READ_STALL    = 4;
  localparam int WRITE_STALL   = 2;
  localparam int ERASE_TICKS   = 16;
  localparam int WRITE_TICKS   = 16;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [1:0] MODE_ATOMIC  = 2'h0;
  localparam logic [1:0] MODE_ERASE   = 2'h1;
  localparam logic [1:0] MODE_WRITE   = 2'h2;
  localparam logic [1:0] AXI_OKAY     = 2'h0;
  localparam logic [1:0] AXI_SLVERR   = 2'h2;

  typedef enum {ST_IDLE, ST_ERASE, ST_WRITE} eebac_state_t;
endpackage

// file: hw/eebac_ticker.sv
// Purpose: oscillator tick generator for program timing
// Assumes: osc_clk is asynchronous to clk
// Notes:   one-cycle tick on each rising osc edge
`timescale 1ns/1ps
`default_nettype none
module eebac_ticker
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic osc_clk,
  output logic      tick
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================
  // synchronise and detect rising edge
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= osc_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign tick = s2_q & ~s3_q;
endmodule
`default_nettype wire

// file: hw/eebac_top.sv
// Purpose: cpu access controller for a byte eeprom
// Assumes: axi4-lite slave on clk, osc_clk from calibrated oscillator
// Notes:   array held in flip-flops; stall pulses toward the core
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - eeprom is its own linear byte space, bytes read and written singly
// - address, data and control registers reachable over the register bus
// - a read stalls the processor for four cycles
// - a program trigger stalls the processor for two cycles
// - mode zero with armed strobe starts combined erase and write
// - mode 01 with armed strobe erases the byte only
// - mode 10 with armed strobe writes data register only
// - program strobe reads set until the operation completes
// - no read or program starts while programming is busy
// - program durations are timed by the calibrated oscillator
// - read strobe loads data register from addressed byte
// - address is nine bits, upper high-byte bits read zero
module eebac_top
#(
  parameter int ERASE_CYC = eebac_pkg::ERASE_TICKS,
  parameter int WRITE_CYC = eebac_pkg::WRITE_TICKS
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        osc_clk,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_stall
);
  import eebac_pkg::*;

  logic [7:0]          mem_q [DEPTH];
  logic [ADDR_W-1:0]   addr_q;
  logic [7:0]          data_q;
  logic [1:0]          mode_q;
  logic                arm_q;
  logic [2:0]          arm_cnt_q;
  logic [2:0]          stall_q;
  logic [15:0]         tcnt_q;
  eebac_state_t        st_q;
  logic                tick;
  logic                busy;
  logic                aw_q;
  logic                w_q;
  logic [3:0]          awa_q;
  logic [31:0]         wd_q;
  logic                wr_go;
  logic [7:0]          wb;
  logic                rd_go;
  logic                prog_go;

  eebac_ticker u_tick
  (
    .clk     (clk),
    .srst    (srst),
    .osc_clk (osc_clk),
    .tick    (tick)
  );

  // ==========================================================
  // axi write channel: take address and data in either order
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign wr_go = aw_q & w_q & ~s_axi_bvalid;
  assign wb    = wd_q[7:0];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awa_q        <= 4'h0;
      wd_q         <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      if (wr_go)
      begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awa_q[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // write with wstrb[0] clear stores nothing
  logic wr_ok;
  logic w_strb_q;
  always_ff @(posedge clk)
  begin
    if (srst)
      w_strb_q <= 1'b0;
    else if (s_axi_wvalid & s_axi_wready)
      w_strb_q <= s_axi_wstrb[0];
  end
  assign wr_ok = wr_go & w_strb_q & ~busy;

  // ==========================================================
  // address and data registers
  assign rd_go   = wr_ok & (awa_q == CTRL_OFS) & wb[RD_STROBE_BIT];
  assign prog_go = wr_ok & (awa_q == CTRL_OFS) & wb[PROG_BIT] & arm_q;
  assign busy    = (st_q != ST_IDLE);

  always_ff @(posedge clk)
  begin
    if (srst)
      addr_q <= '0;
    else if (wr_ok & (awa_q == ADDR_LOW_OFS))
      addr_q[7:0] <= wb;
    else if (wr_ok & (awa_q == ADDR_HIGH_OFS))
      addr_q[8] <= wb[0];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      data_q <= DATA_RESET;
    else if (rd_go)
      data_q <= mem_q[addr_q];
    else if (wr_ok & (awa_q == DATA_OFS))
      data_q <= wb;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      mode_q <= MODE_ATOMIC;
    else if (wr_ok & (awa_q == CTRL_OFS))
      mode_q <= wb[MODE_LSB +: MODE_W];
  end

  // ==========================================================
  // arm bit with four-cycle window
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arm_q     <= 1'b0;
      arm_cnt_q <= 3'h0;
    end
    else if (prog_go)
    begin
      arm_q     <= 1'b0;
      arm_cnt_q <= 3'h0;
    end
    else if (wr_ok & (awa_q == CTRL_OFS) & wb[ARM_BIT])
    begin
      arm_q     <= 1'b1;
      arm_cnt_q <= 3'(ARM_WINDOW);
    end
    else if (arm_cnt_q == 3'h1)
    begin
      arm_q     <= 1'b0;
      arm_cnt_q <= 3'h0;
    end
    else if (arm_cnt_q != 3'h0)
      arm_cnt_q <= arm_cnt_q - 3'h1;
  end

  // ==========================================================
  // processor stall
  always_ff @(posedge clk)
  begin
    if (srst)
      stall_q <= 3'h0;
    else if (rd_go)
      stall_q <= 3'(READ_STALL);
    else if (prog_go)
      stall_q <= 3'(WRITE_STALL);
    else if (stall_q != 3'h0)
      stall_q <= stall_q - 3'h1;
  end
  assign cpu_stall = (stall_q != 3'h0);

  // ==========================================================
  // self-timed programming sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q   <= ST_IDLE;
      tcnt_q <= 16'h0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (prog_go & (mode_q == MODE_WRITE))
          begin
            st_q   <= ST_WRITE;
            tcnt_q <= 16'(WRITE_CYC);
          end
          else if (prog_go & (mode_q != 2'h3))
          begin
            st_q   <= ST_ERASE;
            tcnt_q <= 16'(ERASE_CYC);
          end
        end
        ST_ERASE:
        begin
          if (tick & (tcnt_q == 16'h1))
          begin
            st_q   <= (mode_q == MODE_ATOMIC) ? ST_WRITE : ST_IDLE;
            tcnt_q <= 16'(WRITE_CYC);
          end
          else if (tick)
            tcnt_q <= tcnt_q - 16'h1;
        end
        ST_WRITE:
        begin
          if (tick & (tcnt_q == 16'h1))
            st_q <= ST_IDLE;
          else if (tick)
            tcnt_q <= tcnt_q - 16'h1;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // array update at end of each phase; write-only ands into cell
  always_ff @(posedge clk)
  begin
    if (tick & (tcnt_q == 16'h1) & (st_q == ST_ERASE))
      mem_q[addr_q] <= ERASED_VALUE;
    else if (tick & (tcnt_q == 16'h1) & (st_q == ST_WRITE))
      mem_q[addr_q] <= mem_q[addr_q] & data_q;
  end

  // ==========================================================
  // axi read channel
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= AXI_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? AXI_OKAY : AXI_SLVERR;
      case (s_axi_araddr)
        ADDR_LOW_OFS:  s_axi_rdata <= {24'h0, addr_q[7:0]};
        ADDR_HIGH_OFS: s_axi_rdata <= {31'h0, addr_q[8]};
        DATA_OFS:      s_axi_rdata <= {24'h0, data_q};
        CTRL_OFS:      s_axi_rdata <= {26'h0, mode_q, 1'b0, arm_q,
                                       busy, 1'b0};
        default:       s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // checks
  busy_hold_a: assert property (@(posedge clk) disable iff (srst)
    busy & ~tick |=> busy) else $error("busy dropped without tick");
  read_stall_a: assert property (@(posedge clk) disable iff (srst)
    rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  prog_stall_a: assert property (@(posedge clk) disable iff (srst)
    prog_go |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("program stall not two cycles");
  arm_window_a: assert property (@(posedge clk) disable iff (srst)
    $rose(arm_q) |-> ##[0:4] !arm_q)
    else $error("arm bit held too long");
  no_start_a: assert property (@(posedge clk) disable iff (srst)
    busy |-> !rd_go && !prog_go)
    else $error("operation started while busy");
  erase_only_a: assert property (@(posedge clk) disable iff (srst)
    prog_go && mode_q == MODE_ERASE |=> st_q == ST_ERASE)
    else $error("erase-only did not start");
  write_only_a: assert property (@(posedge clk) disable iff (srst)
    prog_go && mode_q == MODE_WRITE |=> st_q == ST_WRITE)
    else $error("write-only did not start");
  atomic_seq_a: assert property (@(posedge clk) disable iff (srst)
    st_q == ST_ERASE && mode_q == MODE_ATOMIC && tick && tcnt_q == 16'h1
    |=> st_q == ST_WRITE) else $error("atomic write phase skipped");
  read_data_a: assert property (@(posedge clk) disable iff (srst)
    rd_go |=> data_q == mem_q[addr_q])
    else $error("read data mismatch");
endmodule
`default_nettype wire

// file: testbench/eebac_cpu_model.sv
// Purpose: cpu-side register master for the eeprom controller
// Assumes: axi4-lite, one aligned word per register
// Notes:   ready/valid looked at on the falling edge before the taking edge
`timescale 1ns/1ps
`default_nettype none
module eebac_cpu_model
(
  input  wire logic        clk,
  output var  logic [3:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [3:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // ==========================================================
  // idle levels
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
    wstrb  = 4'hF;
    bready = 1'b1;
    rready = 1'b1;
  end
  // ==========================================================
  // one register write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (pa || pw)
    begin
      @(negedge clk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    ta = 1'b0;
    while (!ta)
    begin
      @(negedge clk);
      ta = bvalid;
      @(posedge clk);
    end
  endtask
  // ==========================================================
  // one register read, data and response taken with rvalid
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic t;
    t = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    while (!t)
    begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
      if (t) arvalid <= 1'b0;
    end
    t = 1'b0;
    while (!t)
    begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the byte eeprom access controller
// Assumes: short program counts of 4 oscillator ticks
// Notes:   stall cycles are counted on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eebac_pkg::*;
  logic        clk, srst, osc_clk, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, rv;
  logic        awready, wready, bvalid, arready, rvalid, cpu_stall;
  logic [1:0]  bresp, rresp, rr;
  int          errors, comparisons, nst, polls;
  // ==========================================================
  // clocks, reset, stall counter
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    osc_clk = 1'b0;
    forever #15 osc_clk = ~osc_clk;
  end
  always @(negedge clk) if (cpu_stall === 1'b1) nst++;
  eebac_top #(.ERASE_CYC(4), .WRITE_CYC(4)) eebac_top_i
  (
    .clk(clk), .srst(srst), .osc_clk(osc_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_stall(cpu_stall)
  );
  eebac_cpu_model eebac_cpu_model_i
  (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready)
  );
  // ==========================================================
  // compares and access helpers
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      errors++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    eebac_cpu_model_i.wr(a, d);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    eebac_cpu_model_i.rd(a, rv, rr);
    chk_val(rv, e);
  endtask
  task automatic setaddr(input logic [8:0] a);
    wr(ADDR_LOW_OFS, {24'h0, a[7:0]});
    wr(ADDR_HIGH_OFS, {31'h7FFFFFFF, a[8]});
  endtask
  task automatic wait_idle;
    polls = 0;
    do
    begin
      eebac_cpu_model_i.rd(CTRL_OFS, rv, rr);
      polls++;
    end
    while (rv[PROG_BIT] !== 1'b0 && polls < 300);
    chk_cnt(int'(polls < 300), 1);
  endtask
  task automatic prog(input logic [8:0] a, input logic [7:0] d,
                      input logic [1:0] m);
    setaddr(a);
    wr(DATA_OFS, {24'h0, d});
    wr(CTRL_OFS, (32'(m) << MODE_LSB) | 32'h4);
    nst = 0;
    wr(CTRL_OFS, (32'(m) << MODE_LSB) | 32'h6);
    repeat (4) @(posedge clk);
    chk_cnt(nst, WRITE_STALL);
    eebac_cpu_model_i.rd(CTRL_OFS, rv, rr);
    chk_val({31'h0, rv[PROG_BIT]}, 32'h1);
  endtask
  task automatic rdback(input logic [8:0] a, input logic [7:0] e);
    setaddr(a);
    nst = 0;
    wr(CTRL_OFS, 32'h1);
    repeat (6) @(posedge clk);
    chk_cnt(nst, READ_STALL);
    rdchk(DATA_OFS, {24'h0, e});
  endtask
  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog and main sequence
  initial
  begin
    #400000;
    errors++;
    conclude();
  end
  initial
  begin
    srst = 1'b1;
    errors = 0;
    comparisons = 0;
    nst = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) rdchk(4'(i * 4), 32'h0);
    prog(9'h1FF, 8'hA5, MODE_ATOMIC);
    rdchk(ADDR_HIGH_OFS, 32'h1);
    nst = 0;
    wr(DATA_OFS, 32'h3C);
    wr(CTRL_OFS, 32'h1);
    repeat (6) @(posedge clk);
    chk_cnt(nst, 0);
    wait_idle();
    rdback(9'h1FF, 8'hA5);
    prog(9'h002, 8'h00, MODE_ERASE);
    wait_idle();
    rdback(9'h002, ERASED_VALUE);
    prog(9'h002, 8'h5A, MODE_WRITE);
    wait_idle();
    rdback(9'h002, 8'h5A);
    wr(CTRL_OFS, 32'h34);
    wr(CTRL_OFS, 32'h36);
    eebac_cpu_model_i.rd(CTRL_OFS, rv, rr);
    chk_val({31'h0, rv[PROG_BIT]}, 32'h0);
    wr(DATA_OFS, 32'h11);
    chk_val({30'h0, bresp}, {30'h0, AXI_OKAY});
    wr(CTRL_OFS, 32'h4);
    repeat (8) @(posedge clk);
    wr(CTRL_OFS, 32'h2);
    eebac_cpu_model_i.rd(CTRL_OFS, rv, rr);
    chk_val({31'h0, rv[PROG_BIT]}, 32'h0);
    rdback(9'h002, 8'h5A);
    rdback(9'h1FF, 8'hA5);
    eebac_cpu_model_i.rd(4'h1, rv, rr);
    chk_val({30'h0, rr}, {30'h0, AXI_SLVERR});
    wr(4'h1, 32'h55);
    chk_val({30'h0, bresp}, {30'h0, AXI_SLVERR});
    rdchk(ADDR_LOW_OFS, 32'hFF);
    conclude();
  end
endmodule
`default_nettype wire
